// ### daf_flags.sv
// alarm and warning flag logic with open-drain status pins and warm reset
`timescale 1ns/10ps
// Functional notes
// - twenty threshold conditions, each its own bit in four flag registers
// - alarm bits: temp, supply, bias, tx power high/low; rx power in bits 7:6
// - warning bits use same order as alarm bits
// - high means strictly above; low means strictly below; equality sets nothing
// - a condition becoming true sets its flag
// - flag setting cannot be masked
// - flag stays until its register is read, power cycle, or tx-off toggle
// - while tx off, conversions and flagging continue
// - tx-off deassertion clears all four flag registers
// - rx-loss, rate-select, tx-fault drivers only pull low
// - pins are wired with external pull-down drivers
// - status bits report sampled pin levels
// - warm-reset bit returns the block to power-on defaults, except pin_status, which keeps sampling the pins
// - warm reset releases tx-fault and rx-loss and resets registers
// - warm reset halts conversion and discards partial result
// - state after warm reset equals state after power-on reset, except pin_status, which warm reset does not clear
module daf_flags #(
    parameter int MEAS_W = daf_pkg::MEAS_W
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic warm_reset_i,
    input wire logic tx_off_request_i,
    input wire logic meas_valid_i,
    input wire logic [2:0] meas_param_i,
    input wire logic [MEAS_W-1:0] meas_value_i,
    input wire logic [MEAS_W-1:0] crit_upper_i [daf_pkg::NUM_PARAMS],
    input wire logic [MEAS_W-1:0] crit_lower_i [daf_pkg::NUM_PARAMS],
    input wire logic [MEAS_W-1:0] caut_upper_i [daf_pkg::NUM_PARAMS],
    input wire logic [MEAS_W-1:0] caut_lower_i [daf_pkg::NUM_PARAMS],
    input wire logic [3:0] read_sel_i,
    input wire logic fault_detect_i,
    input wire logic signal_lost_i,
    input wire logic rate_low_i,
    input wire logic tx_fault_line_i,
    input wire logic rx_signal_lost_line_i,
    input wire logic rate_select_line_i,
    output logic tx_fault_line_o,
    output logic tx_fault_line_oe_o,
    output logic rx_signal_lost_line_o,
    output logic rx_signal_lost_line_oe_o,
    output logic rate_select_line_o,
    output logic rate_select_line_oe_o,
    output logic [7:0] critical_flags_lo_o,
    output logic [7:0] critical_flags_hi_o,
    output logic [7:0] caution_flags_lo_o,
    output logic [7:0] caution_flags_hi_o,
    output logic [2:0] pin_status_o,
    output logic [MEAS_W-1:0] result_o,
    output logic [2:0] result_param_o,
    output logic result_valid_o
);
    logic [7:0] critical_flags_lo;
    logic [7:0] critical_flags_hi;
    logic [7:0] caution_flags_lo;
    logic [7:0] caution_flags_hi;
    logic tx_off_q;
    logic [2:0] pin_status;
    logic [MEAS_W-1:0] conv_value;
    logic [2:0] conv_param;
    logic [4:0] conv_cnt;
    daf_pkg::daf_adc_e adc_state;
    daf_pkg::daf_adc_e next_adc_state;
    localparam int NUM_PARAMS_L = daf_pkg::NUM_PARAMS;
    logic [NUM_PARAMS_L-1:0] hi_crit;
    logic [NUM_PARAMS_L-1:0] lo_crit;
    logic [NUM_PARAMS_L-1:0] hi_caut;
    logic [NUM_PARAMS_L-1:0] lo_caut;

    // result presented to the comparators only on the store state
    wire logic eval_now = (adc_state == daf_pkg::DAF_STORE);
    wire logic tx_off_fall = tx_off_q & ~tx_off_request_i;
    wire logic soft_clr = warm_reset_i | tx_off_fall;
    wire logic clr_crit_lo = |(read_sel_i & daf_pkg::SEL_CRIT_LO);
    wire logic clr_crit_hi = |(read_sel_i & daf_pkg::SEL_CRIT_HI);
    wire logic clr_caut_lo = |(read_sel_i & daf_pkg::SEL_CAUT_LO);
    wire logic clr_caut_hi = |(read_sel_i & daf_pkg::SEL_CAUT_HI);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PARAMS_L; gi++) begin : g_cmp
            wire logic sel = eval_now && (conv_param == 3'(gi));
            assign hi_crit[gi] = sel && (conv_value > crit_upper_i[gi]);
            assign lo_crit[gi] = sel && (conv_value < crit_lower_i[gi]);
            assign hi_caut[gi] = sel && (conv_value > caut_upper_i[gi]);
            assign lo_caut[gi] = sel && (conv_value < caut_lower_i[gi]);
        end
    endgenerate

    // bit order: temp hi/lo, supply hi/lo, bias hi/lo, tx power hi/lo
    wire logic [7:0] ev_crit_lo = {hi_crit[0], lo_crit[0], hi_crit[1],
        lo_crit[1], hi_crit[2], lo_crit[2], hi_crit[3], lo_crit[3]};
    wire logic [7:0] ev_crit_hi = {hi_crit[4], lo_crit[4], 6'h00};
    wire logic [7:0] ev_caut_lo = {hi_caut[0], lo_caut[0], hi_caut[1],
        lo_caut[1], hi_caut[2], lo_caut[2], hi_caut[3], lo_caut[3]};
    wire logic [7:0] ev_caut_hi = {hi_caut[4], lo_caut[4], 6'h00};

    // clear first, then event bits or-ed in so a coincident event survives
    // warm reset beats even a coincident event, as power-on would
    wire logic [7:0] next_crit_lo = warm_reset_i ? daf_pkg::FLAGS_RESET :
        ((soft_clr || clr_crit_lo) ? ev_crit_lo :
        (critical_flags_lo | ev_crit_lo));
    wire logic [7:0] next_crit_hi = warm_reset_i ? daf_pkg::FLAGS_RESET :
        ((soft_clr || clr_crit_hi) ? ev_crit_hi :
        (critical_flags_hi | ev_crit_hi));
    wire logic [7:0] next_caut_lo = warm_reset_i ? daf_pkg::FLAGS_RESET :
        ((soft_clr || clr_caut_lo) ? ev_caut_lo :
        (caution_flags_lo | ev_caut_lo));
    wire logic [7:0] next_caut_hi = warm_reset_i ? daf_pkg::FLAGS_RESET :
        ((soft_clr || clr_caut_hi) ? ev_caut_hi :
        (caution_flags_hi | ev_caut_hi));

    always_comb begin
        next_adc_state = adc_state;
        case (adc_state)
            daf_pkg::DAF_IDLE: begin
                if (meas_valid_i) begin
                    next_adc_state = daf_pkg::DAF_CONV;
                end
            end
            daf_pkg::DAF_CONV: begin
                if (conv_cnt == daf_pkg::ADC_DONE_COUNT) begin
                    next_adc_state = daf_pkg::DAF_STORE;
                end
            end
            daf_pkg::DAF_STORE: next_adc_state = daf_pkg::DAF_IDLE;
            default: next_adc_state = daf_pkg::DAF_IDLE;
        endcase
        // conversions run regardless of tx-off; warm reset aborts them
        if (warm_reset_i) begin
            next_adc_state = daf_pkg::DAF_IDLE;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            adc_state <= daf_pkg::DAF_IDLE;
            conv_cnt <= 5'h00;
            conv_value <= '0;
            conv_param <= 3'h0;
        end else begin
            adc_state <= next_adc_state;
            if (warm_reset_i || adc_state != daf_pkg::DAF_CONV) begin
                conv_cnt <= 5'h00;
            end else begin
                conv_cnt <= conv_cnt + 5'h01;
            end
            if (warm_reset_i) begin
                conv_value <= '0;
                conv_param <= 3'h0;
            end else if (adc_state == daf_pkg::DAF_IDLE && meas_valid_i) begin
                conv_value <= meas_value_i;
                conv_param <= meas_param_i;
            end
        end
    end

    // published results only change on a completed conversion or a warm reset
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            result_o <= '0;
            result_param_o <= 3'h0;
            result_valid_o <= 1'b0;
        end else if (warm_reset_i) begin
            result_o <= '0;
            result_param_o <= 3'h0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= eval_now;
            if (eval_now) begin
                result_o <= conv_value;
                result_param_o <= conv_param;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            critical_flags_lo <= daf_pkg::FLAGS_RESET;
            critical_flags_hi <= daf_pkg::FLAGS_RESET;
            caution_flags_lo <= daf_pkg::FLAGS_RESET;
            caution_flags_hi <= daf_pkg::FLAGS_RESET;
            tx_off_q <= 1'b0;
        end else begin
            critical_flags_lo <= next_crit_lo;
            critical_flags_hi <= next_crit_hi;
            caution_flags_lo <= next_caut_lo;
            caution_flags_hi <= next_caut_hi;
            tx_off_q <= warm_reset_i ? 1'b0 : tx_off_request_i;
        end
    end

    // open drain: oe low means pulling the pin low
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_fault_line_oe_o <= 1'b1;
            rx_signal_lost_line_oe_o <= 1'b1;
            rate_select_line_oe_o <= 1'b1;
            pin_status <= 3'h0;
            tx_fault_line_o <= 1'b0;
            rx_signal_lost_line_o <= 1'b0;
            rate_select_line_o <= 1'b0;
        end else begin
            tx_fault_line_o <= 1'b0;
            rx_signal_lost_line_o <= 1'b0;
            rate_select_line_o <= 1'b0;
            tx_fault_line_oe_o <= warm_reset_i | ~fault_detect_i;
            rx_signal_lost_line_oe_o <= warm_reset_i | ~signal_lost_i;
            rate_select_line_oe_o <= warm_reset_i | ~rate_low_i;
            pin_status <= {rate_select_line_i, rx_signal_lost_line_i,
                tx_fault_line_i};
        end
    end

    assign critical_flags_lo_o = critical_flags_lo;
    assign critical_flags_hi_o = critical_flags_hi;
    assign caution_flags_lo_o = caution_flags_lo;
    assign caution_flags_hi_o = caution_flags_hi;
    assign pin_status_o = pin_status;

    sequence s_event_crit_lo;
        !soft_clr && (ev_crit_lo != 8'h00);
    endsequence

    sequence s_rx_over_crit;
        eval_now && !warm_reset_i && conv_param == daf_pkg::PARAM_RXPWR
        && conv_value > crit_upper_i[daf_pkg::PARAM_RXPWR];
    endsequence

    sequence s_temp_under_caut;
        eval_now && !warm_reset_i && conv_param == daf_pkg::PARAM_TEMP
        && conv_value < caut_lower_i[daf_pkg::PARAM_TEMP];
    endsequence

    a_flag_latches: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        s_event_crit_lo |=> ((critical_flags_lo & $past(ev_crit_lo))
        == $past(ev_crit_lo))) else $error("event lost");
    a_read_keeps_event: assert property (@(posedge mclk_i)
        disable iff (reset_i) (clr_caut_lo && !soft_clr)
        |=> caution_flags_lo == $past(ev_caut_lo))
        else $error("read clear wrong");
    a_sticky_hold: assert property (@(posedge mclk_i)
        disable iff (reset_i) (!soft_clr && !clr_crit_hi) |=>
        ((critical_flags_hi & $past(critical_flags_hi))
        == $past(critical_flags_hi))) else $error("flag dropped");
    a_txoff_clear: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (tx_off_fall && !eval_now) |=> (critical_flags_lo == 8'h00
        && caution_flags_hi == 8'h00)) else $error("tx-off no clear");
    a_equal_no_flag: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (eval_now && conv_param == daf_pkg::PARAM_TEMP
        && conv_value == crit_upper_i[0]) |-> !ev_crit_lo[7])
        else $error("equality flagged");
    a_unused_zero: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        critical_flags_hi[5:0] == 6'h00 && caution_flags_hi[5:0] == 6'h00)
        else $error("unused bits set");
    a_warm_abort: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        warm_reset_i |=> (adc_state == daf_pkg::DAF_IDLE && !result_valid_o
        && tx_fault_line_oe_o && rx_signal_lost_line_oe_o))
        else $error("warm reset incomplete");
    a_pin_status: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        !$past(reset_i) |-> pin_status == $past({rate_select_line_i,
        rx_signal_lost_line_i, tx_fault_line_i}))
        else $error("pin status stale");
    a_txoff_runs: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (tx_off_request_i && adc_state == daf_pkg::DAF_CONV && !warm_reset_i
        && conv_cnt == daf_pkg::ADC_DONE_COUNT) |=> eval_now)
        else $error("conversion stalled");
    a_warm_defaults: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        warm_reset_i |=> (critical_flags_lo == 8'h00
        && critical_flags_hi == 8'h00 && caution_flags_lo == 8'h00
        && caution_flags_hi == 8'h00 && result_o == '0
        && conv_cnt == 5'h00 && !tx_off_q))
        else $error("warm reset left state");
    a_warm_halts: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (warm_reset_i && adc_state == daf_pkg::DAF_CONV) |=> !eval_now)
        else $error("conversion not halted");
    a_store_count: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        eval_now |-> $past(conv_cnt) == daf_pkg::ADC_DONE_COUNT)
        else $error("conversion length wrong");
    a_result_pulse: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        result_valid_o |-> $past(eval_now) && !$past(warm_reset_i))
        else $error("result without conversion");
    a_rx_high_set: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        s_rx_over_crit |=> critical_flags_hi[7])
        else $error("rx power alarm missed");
    a_temp_low_warn: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        s_temp_under_caut |=> caution_flags_lo[6])
        else $error("temp warning missed");
    a_quiet_hold: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (!soft_clr && !clr_caut_hi && ev_caut_hi == 8'h00)
        |=> caution_flags_hi == $past(caution_flags_hi))
        else $error("flag changed while idle");
    a_pull_follows: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        (fault_detect_i && !warm_reset_i) |=> !tx_fault_line_oe_o)
        else $error("pin not pulled low");
    a_never_high: assert property (@(posedge mclk_i)
        disable iff (reset_i)
        !tx_fault_line_o && !rx_signal_lost_line_o && !rate_select_line_o)
        else $error("open drain drove high");
endmodule

// ### daf_pkg.sv
// shared constants for the diagnostic alarm and warning flag block
package daf_pkg;
    localparam int MEAS_W = 16;
    localparam int NUM_PARAMS = 5;
    localparam int NUM_CONDS = 20;
    localparam logic [2:0] PARAM_TEMP = 3'h0;
    localparam logic [2:0] PARAM_SUPPLY = 3'h1;
    localparam logic [2:0] PARAM_BIAS = 3'h2;
    localparam logic [2:0] PARAM_TXPWR = 3'h3;
    localparam logic [2:0] PARAM_RXPWR = 3'h4;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [4:0] ADC_DONE_COUNT = 5'h10;
    localparam logic [3:0] SEL_CRIT_LO = 4'h1;
    localparam logic [3:0] SEL_CRIT_HI = 4'h2;
    localparam logic [3:0] SEL_CAUT_LO = 4'h4;
    localparam logic [3:0] SEL_CAUT_HI = 4'h8;
    typedef enum logic [2:0] {
        DAF_IDLE = 3'b001,
        DAF_CONV = 3'b010,
        DAF_STORE = 3'b100
    } daf_adc_e;
endpackage

// ### daf_pin_model.sv
// open-drain pin wiring with pull-ups and external pull-down drivers
`timescale 1ns/10ps
module daf_pin_model (
    input wire logic [2:0] dev_oe_n_i,
    input wire logic [2:0] dev_data_i,
    input wire logic [2:0] ext_pull_i,
    output logic [2:0] level_o
);
    // pull-up wins unless either party pulls low
    assign level_o = ~((~dev_oe_n_i & ~dev_data_i) | ext_pull_i);
endmodule

// ### tb.sv
// self-checking bench for the alarm and warning flag block
`timescale 1ns/10ps
module tb;
    logic mclk_i = 0, reset_i = 1, warm_reset_i = 0, tx_off = 0;
    logic meas_valid_i = 0;
    logic [2:0] meas_param_i = 0, req = 0, ext = 0;
    logic [15:0] meas_value_i = 0;
    logic [15:0] cu [5], cl [5], wu [5], wl [5];
    logic [3:0] read_sel_i = 0;
    wire [2:0] lvl, oe_n, dat, pin_status_o, result_param_o;
    wire [7:0] c_lo, c_hi, w_lo, w_hi;
    wire [15:0] result_o;
    wire result_valid_o;
    int n_errors = 0, n_tests = 0, cnt;
    // param, value, {crit_hi, crit_lo, caut_hi, caut_lo}
    logic [51:0] rows [13] = '{
        52'h0_0801_0080_0080, 52'h0_0800_0000_0080, 52'h0_0600_0000_0000,
        52'h1_00ff_0010_0010, 52'h1_0200_0000_0000, 52'h2_0601_0000_0008,
        52'h2_0100_0000_0004, 52'h3_0900_0002_0002, 52'h3_0000_0001_0001,
        52'h3_0100_0000_0001, 52'h4_0801_8000_8000, 52'h4_01ff_0000_4000,
        52'h4_0000_4000_4000};
    always #5 mclk_i = ~mclk_i;
    daf_flags daf_flags_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .warm_reset_i(warm_reset_i),
        .tx_off_request_i(tx_off), .meas_valid_i(meas_valid_i),
        .meas_param_i(meas_param_i), .meas_value_i(meas_value_i),
        .crit_upper_i(cu), .crit_lower_i(cl), .caut_upper_i(wu),
        .caut_lower_i(wl), .read_sel_i(read_sel_i),
        .fault_detect_i(req[0]), .signal_lost_i(req[1]),
        .rate_low_i(req[2]), .tx_fault_line_i(lvl[0]),
        .rx_signal_lost_line_i(lvl[1]), .rate_select_line_i(lvl[2]),
        .tx_fault_line_o(dat[0]), .tx_fault_line_oe_o(oe_n[0]),
        .rx_signal_lost_line_o(dat[1]), .rx_signal_lost_line_oe_o(oe_n[1]),
        .rate_select_line_o(dat[2]), .rate_select_line_oe_o(oe_n[2]),
        .critical_flags_lo_o(c_lo), .critical_flags_hi_o(c_hi),
        .caution_flags_lo_o(w_lo), .caution_flags_hi_o(w_hi),
        .pin_status_o(pin_status_o), .result_o(result_o),
        .result_param_o(result_param_o), .result_valid_o(result_valid_o));
    daf_pin_model daf_pin_model_inst (.dev_oe_n_i(oe_n), .dev_data_i(dat),
        .ext_pull_i(ext), .level_o(lvl));
    task automatic stop_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_flags(input logic [31:0] e);
        n_tests++;
        if ({c_hi, c_lo, w_hi, w_lo} !== e) begin
            n_errors++;
            $display("[FAIL] %0t flags %h exp %h", $time,
                {c_hi, c_lo, w_hi, w_lo}, e);
        end
    endtask
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t value %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic measure(input logic [2:0] p, input logic [15:0] v);
        @(posedge mclk_i);
        meas_valid_i <= 1'b1;
        meas_param_i <= p;
        meas_value_i <= v;
        @(posedge mclk_i);
        meas_valid_i <= 1'b0;
    endtask
    task automatic wait_result();
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge mclk_i);
            if (result_valid_o === 1'b1) break;
        end
        chk_val(16'(i == 40), 16'h0);
    endtask
    task automatic read(input logic [3:0] s);
        @(posedge mclk_i);
        read_sel_i <= s;
        @(posedge mclk_i);
        read_sel_i <= 4'h0;
        @(negedge mclk_i);
    endtask
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial begin
        for (int k = 0; k < 5; k++) begin
            cu[k] <= 16'h0800;
            cl[k] <= 16'h0100;
            wu[k] <= 16'h0600;
            wl[k] <= 16'h0200;
        end
        tick(2);
        @(negedge mclk_i);
        chk_flags(32'h0);
        chk_val({13'h0, oe_n}, 16'h0007);
        @(posedge mclk_i) reset_i <= 1'b0;
        foreach (rows[k]) begin
            measure(rows[k][50:48], rows[k][47:32]);
            wait_result();
            chk_flags(rows[k][31:0]);
            chk_val(result_o, rows[k][47:32]);
            chk_val(16'(result_param_o), 16'(rows[k][50:48]));
            read(4'hf);
            chk_flags(32'h0);
        end
        measure(3'h0, 16'h0000);
        wait_result();
        measure(3'h4, 16'h0000);
        wait_result();
        read(4'h1);
        chk_flags(32'h4000_4040);
        read(4'h4);
        chk_flags(32'h4000_4000);
        @(posedge mclk_i) tx_off <= 1'b1;
        measure(3'h1, 16'h0fff);
        wait_result();
        chk_val(result_o, 16'h0fff);
        chk_flags(32'h4020_4020);
        @(posedge mclk_i) tx_off <= 1'b0;
        tick(2);
        @(negedge mclk_i);
        chk_flags(32'h0);
        measure(3'h3, 16'h0900);
        tick(14);
        read_sel_i <= 4'hf;
        tick(4);
        read_sel_i <= 4'h0;
        @(negedge mclk_i);
        chk_flags(32'h0002_0002);
        @(posedge mclk_i) req <= 3'b111;
        tick(3);
        @(negedge mclk_i);
        chk_val({7'h0, oe_n, dat, pin_status_o}, 16'h0);
        @(posedge mclk_i) req <= 3'b000;
        @(posedge mclk_i) ext <= 3'b010;
        tick(3);
        @(negedge mclk_i);
        chk_val({7'h0, oe_n, dat, pin_status_o}, 16'h01c5);
        @(posedge mclk_i) ext <= 3'b000;
        req <= 3'b011;
        measure(3'h2, 16'h0000);
        tick(5);
        warm_reset_i <= 1'b1;
        tick(2);
        @(negedge mclk_i);
        chk_val({13'h0, oe_n}, 16'h0007);
        chk_flags(32'h0);
        @(posedge mclk_i) warm_reset_i <= 1'b0;
        req <= 3'b000;
        cnt = 0;
        repeat (30) begin
            @(negedge mclk_i);
            cnt += int'(result_valid_o !== 1'b0);
        end
        chk_val(16'(cnt), 16'h0);
        chk_val(result_o, 16'h0);
        measure(3'h2, 16'h0000);
        wait_result();
        chk_flags(32'h0004_0004);
        stop_test();
    end
endmodule
